// >>> egfp_top.v
`timescale 1ns/1ps
`include "egfp_consts.vh"

module egfp_top #(
  parameter [31:0] PER_TMO_TICKS = `PER_TMO_S * `TICKS_PER_S
) (
  input  wire        i_ref_clk,
  input  wire        i_rst_b,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output wire        o_pslverr,
  input  wire        i_enc_a,
  input  wire        i_enc_b,
  input  wire        i_enc_c,
  input  wire        i_gate,
  input  wire        i_ext_rst
);

  // Address decode shared by write strobe and error answer
  function egfp_mapped;
    input [11:0] a;
    begin
      case (a)
        `REG_CTRL, `REG_STATUS, `REG_COUNT, `REG_LATCH2,
        `REG_FWIN, `REG_FSCALE, `REG_FWAIT, `REG_PSCALE,
        `REG_FREQ, `REG_PERIOD: egfp_mapped = 1'b1;
        default: egfp_mapped = 1'b0;
      endcase
    end
  endfunction

  // Software registers
  reg         sw_gate;
  reg         l2_rise_en;
  reg         l2_fall_en;
  reg         c_rst_en;
  reg  [1:0]  gate_pol;
  reg  [31:0] fwin_us;
  reg  [31:0] fscale;
  reg  [31:0] fwait_ms;
  reg  [31:0] pscale;

  // Block state
  reg         sw_ok;
  reg         l2_valid;
  reg  [31:0] count;
  reg  [31:0] latch2;
  reg  [31:0] freq;
  reg  [31:0] period;
  reg         a_q;
  reg         c_q;
  reg         g_q;

  // Timebase
  reg  [1:0]  div_cnt;
  reg  [31:0] tb;
  wire        tick = (div_cnt == (`TICK_DIV - 2'h1));

  // Frequency path
  reg  [31:0] win_cnt;
  reg  [31:0] wait_cnt;
  reg         f_arm;
  reg  [31:0] f_rises;
  reg  [31:0] f_per;
  reg  [31:0] f_t0;
  reg  [31:0] f_tend;
  reg         f_start;
  reg  [63:0] f_num;
  reg  [31:0] f_den;
  wire        f_busy;
  wire        f_done;
  wire [31:0] f_quo;

  // Period path
  reg         p_run;
  reg  [31:0] p_last;
  reg         p_start;
  reg  [63:0] p_num;
  reg  [31:0] p_den;
  wire        p_busy;
  wire        p_done;
  wire [31:0] p_quo;

  // Edges of the encoder and gate inputs
  wire        a_rise = i_enc_a & ~a_q;
  wire        a_fall = ~i_enc_a & a_q;
  wire        c_rise = i_enc_c & ~c_q;
  wire        g_rise = i_gate & ~g_q;
  wire        g_fall = ~i_gate & g_q;

  // APB strobes
  wire        acc    = i_psel & i_penable;
  wire        hit    = egfp_mapped(i_paddr);
  wire        wr     = acc & i_pwrite & hit;

  assign o_pready  = 1'b1;
  assign o_pslverr = acc & ~hit;

  // Gate level qualifier per polarity
  wire gate_lvl = ((gate_pol == `GATE_POS) & i_gate) |
                  ((gate_pol == `GATE_NEG) & ~i_gate);
  wire frozen   = gate_lvl | sw_gate;

  // Latch2 edge qualifier
  wire l2_hit   = ~l2_valid &
                  ((l2_rise_en & g_rise) | (l2_fall_en & g_fall));

  // Thresholds in ticks
  wire [31:0] win_thr  = fwin_us * `TICKS_PER_US;
  wire [31:0] wait_thr = fwait_ms * `TICKS_PER_MS;
  wire        win_done = tick & (win_cnt >= (win_thr - 32'h1));
  wire [31:0] p_age    = tb - p_last;

  // Dividends and divisors
  wire [63:0] f_k      = (fscale == `FSCALE_HZ) ? `FREQ_K_HZ
                                                : `FREQ_K_CENTI;
  wire [63:0] f_prod   = {32'h00000000, f_per} * f_k;
  wire [63:0] p_prod   = {32'h00000000, p_age} * `PER_MUL;
  wire [31:0] p_div    = (pscale == 32'h0) ? `PSCALE_TB : pscale;

  // Register writes and sampled edges
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sw_gate    <= 1'b0;
      l2_rise_en <= 1'b0;
      l2_fall_en <= 1'b0;
      c_rst_en   <= 1'b0;
      gate_pol   <= `GATE_OFF;
      fwin_us    <= `RST_FWIN;
      fscale     <= `RST_FSCALE;
      fwait_ms   <= `RST_FWAIT;
      pscale     <= `RST_PSCALE;
      a_q        <= 1'b0;
      c_q        <= 1'b0;
      g_q        <= 1'b0;
    end else begin
      a_q <= i_enc_a;
      c_q <= i_enc_c;
      g_q <= i_gate;
      if (wr) begin
        case (i_paddr)
          `REG_CTRL: begin
            sw_gate    <= i_pwdata[`CTRL_SWGATE];
            l2_rise_en <= i_pwdata[`CTRL_L2RISE];
            l2_fall_en <= i_pwdata[`CTRL_L2FALL];
            c_rst_en   <= i_pwdata[`CTRL_CRST];
            gate_pol   <= i_pwdata[`CTRL_POL_HI:`CTRL_POL_LO];
          end
          `REG_FWIN:   fwin_us  <= i_pwdata;
          `REG_FSCALE: fscale   <= i_pwdata;
          `REG_FWAIT:  fwait_ms <= i_pwdata;
          `REG_PSCALE: pscale   <= i_pwdata;
          default: begin
          end
        endcase
      end
    end
  end

  // Read data, loaded in setup cycle, zero outside access
  always @(posedge i_ref_clk) begin
    o_prdata <= 32'h00000000;
    if (i_rst_b & i_psel & ~i_penable & ~i_pwrite) begin
      case (i_paddr)
        `REG_CTRL: begin
          o_prdata[`CTRL_SWGATE] <= sw_gate;
          o_prdata[`CTRL_L2RISE] <= l2_rise_en;
          o_prdata[`CTRL_L2FALL] <= l2_fall_en;
          o_prdata[`CTRL_CRST]   <= c_rst_en;
          o_prdata[`CTRL_POL_HI:`CTRL_POL_LO] <= gate_pol;
        end
        `REG_STATUS: begin
          o_prdata[`ST_GATE]   <= i_gate;
          o_prdata[`ST_SWOK]   <= sw_ok;
          o_prdata[`ST_L2VAL]  <= l2_valid;
          o_prdata[`ST_FROZEN] <= frozen;
        end
        `REG_COUNT:  o_prdata <= count;
        `REG_LATCH2: o_prdata <= latch2;
        `REG_FWIN:   o_prdata <= fwin_us;
        `REG_FSCALE: o_prdata <= fscale;
        `REG_FWAIT:  o_prdata <= fwait_ms;
        `REG_PSCALE: o_prdata <= pscale;
        `REG_FREQ:   o_prdata <= freq;
        `REG_PERIOD: o_prdata <= period;
        default:     o_prdata <= 32'h00000000;
      endcase
    end
  end

  // Position counter, gate freeze and second capture
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      count    <= 32'h00000000;
      latch2   <= 32'h00000000;
      l2_valid <= 1'b0;
      sw_ok    <= 1'b0;
    end else begin
      sw_ok <= sw_gate;
      // Capture uses the value before this edge can freeze
      if (l2_hit) begin
        latch2   <= count;
        l2_valid <= 1'b1;
      end else if (~l2_rise_en & ~l2_fall_en) begin
        l2_valid <= 1'b0;
      end
      if (i_ext_rst | (c_rst_en & c_rise)) begin
        count <= 32'h00000000;
      end else if (~frozen & a_rise) begin
        count <= i_enc_b ? (count - 32'h1) : (count + 32'h1);
      end
    end
  end

  // Free running 10 ns timebase
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      div_cnt <= 2'h0;
      tb      <= 32'h00000000;
    end else begin
      if (tick) begin
        div_cnt <= 2'h0;
        tb      <= tb + 32'h1;
      end else begin
        div_cnt <= div_cnt + 2'h1;
      end
    end
  end

  // Frequency window sequencing, untouched by gate or counter resets
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      win_cnt  <= 32'h00000000;
      wait_cnt <= 32'h00000000;
      f_arm    <= 1'b0;
      f_rises  <= 32'h00000000;
      f_per    <= 32'h00000000;
      f_t0     <= 32'h00000000;
      f_tend   <= 32'h00000000;
      f_start  <= 1'b0;
      f_num    <= 64'h0000000000000000;
      f_den    <= 32'h00000000;
      freq     <= 32'h00000000;
    end else begin
      f_start <= 1'b0;
      if (tick) begin
        win_cnt  <= win_cnt + 32'h1;
        wait_cnt <= wait_cnt + 32'h1;
      end
      if (f_done) begin
        freq <= f_quo;
      end
      if (win_done) begin
        win_cnt <= 32'h00000000;
        f_arm   <= 1'b0;
        f_rises <= 32'h00000000;
        f_per   <= 32'h00000000;
        if (f_per != 32'h0) begin
          wait_cnt <= 32'h00000000;
          if (!f_busy) begin
            f_start <= 1'b1;
            f_num   <= f_prod;
            f_den   <= f_tend - f_t0;
          end
        end else if (wait_cnt >= wait_thr) begin
          wait_cnt <= 32'h00000000;
          freq     <= 32'h00000000;
        end
        // Otherwise a fresh window starts, freq held
      end else begin
        if (a_rise) begin
          if (!f_arm) begin
            f_arm   <= 1'b1;
            f_t0    <= tb;
            f_rises <= 32'h00000000;
          end else begin
            f_rises <= f_rises + 32'h1;
          end
        end
        if (a_fall & f_arm & (f_rises != 32'h0)) begin
          f_per  <= f_rises;
          f_tend <= tb;
        end
      end
    end
  end

  // Period timing between rising edges of track A
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      p_run   <= 1'b0;
      p_last  <= 32'h00000000;
      p_start <= 1'b0;
      p_num   <= 64'h0000000000000000;
      p_den   <= 32'h00000000;
      period  <= 32'h00000000;
    end else begin
      p_start <= 1'b0;
      if (p_done) begin
        period <= p_quo;
      end
      if (a_rise) begin
        p_last <= tb;
        p_run  <= 1'b1;
        if (p_run & ~p_busy) begin
          p_start <= 1'b1;
          p_num   <= p_prod;
          p_den   <= p_div;
        end
      end else if (p_run & (p_age >= PER_TMO_TICKS)) begin
        p_run  <= 1'b0;
        period <= `PER_MAX;
      end
      // No edge, no timeout and no divider result keeps period as it is
    end
  end

  // Frequency divider
  egfp_div u_fdiv (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_start   (f_start),
    .i_num     (f_num),
    .i_den     (f_den),
    .o_busy    (f_busy),
    .o_done    (f_done),
    .o_quo     (f_quo)
  );

  // Period scaling divider
  egfp_div u_pdiv (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_start   (p_start),
    .i_num     (p_num),
    .i_den     (p_den),
    .o_busy    (p_busy),
    .o_done    (p_done),
    .o_quo     (p_quo)
  );

endmodule // egfp_top

// >>> egfp_consts.vh
`ifndef EGFP_CONSTS_VH
`define EGFP_CONSTS_VH

// Clock and timebase
`define CLK_NS          32'd5
`define TB_NS           32'd10
`define TICK_DIV        (`TB_NS / `CLK_NS)
`define TICKS_PER_US    (32'd1000 / `TB_NS)
`define TICKS_PER_MS    (32'd1000000 / `TB_NS)
`define TICKS_PER_S     (32'd1000000000 / `TB_NS)

// Period timeout
`define PER_TMO_S       32'd21
`define PER_MAX         32'h80000000

// Frequency and period scaling constants for ticks of 10 ns
`define FREQ_K_HZ       64'h0000000005F5E100
`define FREQ_K_CENTI    64'h00000002540BE400
`define FSCALE_HZ       32'd1
`define PSCALE_TB       32'd10
`define PER_MUL         64'h000000000000000A

// Gate polarity codes
`define GATE_OFF        2'h0
`define GATE_POS        2'h1
`define GATE_NEG        2'h2

// Register byte offsets
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_COUNT       12'h008
`define REG_LATCH2      12'h00C
`define REG_FWIN        12'h010
`define REG_FSCALE      12'h014
`define REG_FWAIT       12'h018
`define REG_PSCALE      12'h01C
`define REG_FREQ        12'h020
`define REG_PERIOD      12'h024

// Control fields
`define CTRL_SWGATE     0
`define CTRL_L2RISE     1
`define CTRL_L2FALL     2
`define CTRL_CRST       3
`define CTRL_POL_LO     4
`define CTRL_POL_HI     5

// Status fields
`define ST_GATE         0
`define ST_SWOK         1
`define ST_L2VAL        2
`define ST_FROZEN       3

// Reset values
`define RST_FWIN        32'd10000
`define RST_FSCALE      32'd100
`define RST_FWAIT       32'd1000
`define RST_PSCALE      32'd10

// Divider
`define DIV_STEPS       7'd64

`endif

// >>> egfp_div.v
`timescale 1ns/1ps
`include "egfp_consts.vh"

module egfp_div (
  input  wire        i_ref_clk,
  input  wire        i_rst_b,
  input  wire        i_start,
  input  wire [63:0] i_num,
  input  wire [31:0] i_den,
  output reg         o_busy,
  output reg         o_done,
  output reg  [31:0] o_quo
);

  reg  [6:0]  cnt;
  reg  [32:0] rem;
  reg  [63:0] quo;
  reg  [31:0] den;
  wire [32:0] sh   = {rem[31:0], quo[63]};
  wire        ge   = (sh >= {1'b0, den});
  wire [32:0] nrem = ge ? (sh - {1'b0, den}) : sh;
  wire [63:0] nquo = {quo[62:0], ge};

  // Restoring division, one bit per clock, saturating result
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_quo  <= 32'h00000000;
      cnt    <= 7'h00;
      rem    <= 33'h000000000;
      quo    <= 64'h0000000000000000;
      den    <= 32'h00000000;
    end else begin
      o_done <= 1'b0;
      if (o_busy) begin
        rem <= nrem;
        quo <= nquo;
        cnt <= cnt - 7'h01;
        if (cnt == 7'h01) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          o_quo  <= (|nquo[63:32]) ? 32'hFFFFFFFF : nquo[31:0];
        end
      end else if (i_start) begin
        o_busy <= 1'b1;
        cnt    <= `DIV_STEPS;
        rem    <= 33'h000000000;
        quo    <= i_num;
        den    <= i_den;
      end
    end
  end

endmodule // egfp_div

// >>> egfp_enc_model.sv
`timescale 1ns/1ps

module egfp_enc_model (
  input  wire        i_ref_clk,
  input  wire        i_run,
  input  wire [15:0] i_half,
  output reg         o_enc_a
);
  reg [15:0] cnt;

  // Track A square wave, parked low while stopped
  always @(posedge i_ref_clk) begin
    if (!i_run) begin
      cnt     <= 16'h0000;
      o_enc_a <= 1'b0;
    end else if (cnt >= i_half - 16'h0001) begin
      cnt     <= 16'h0000;
      o_enc_a <= !o_enc_a;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule // egfp_enc_model

// >>> egfp_monitor.sv
`timescale 1ns/1ps
`include "egfp_consts.vh"

module egfp_monitor #(
  parameter [31:0] PER_TMO_TICKS = `PER_TMO_S * `TICKS_PER_S
) (
  input wire        i_ref_clk,
  input wire        i_rst_b,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire        o_pready,
  input wire [31:0] o_prdata,
  input wire        o_pslverr,
  input wire        i_enc_a,
  input wire        i_enc_b,
  input wire        i_enc_c,
  input wire        i_gate,
  input wire        i_ext_rst
);
  localparam [33:0] LIM = 2 * PER_TMO_TICKS + 200;
  wire       acc    = i_psel && i_penable;
  wire       rd_st  = acc && !i_pwrite && (i_paddr == `REG_STATUS);
  wire       mapped = (i_paddr[1:0] == 2'h0) && (i_paddr <= `REG_PERIOD);
  reg        sh_sw;
  reg  [1:0] sh_pol;
  reg [31:0] idle;
  reg        seen;
  reg        a_q;

  // Shadow of control word, idle time since last A rise
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sh_sw  <= 1'b0;
      sh_pol <= 2'h0;
      idle   <= 32'h00000000;
      seen   <= 1'b0;
      a_q    <= 1'b0;
    end else begin
      a_q <= i_enc_a;
      if (acc && i_pwrite && i_paddr == `REG_CTRL) begin
        sh_sw  <= i_pwdata[`CTRL_SWGATE];
        sh_pol <= i_pwdata[`CTRL_POL_HI:`CTRL_POL_LO];
      end
      if (i_enc_a && !a_q) begin
        idle <= 32'h00000000;
        seen <= 1'b1;
      end else if (idle != 32'hFFFFFFFF) begin
        idle <= idle + 32'h00000001;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_gate_held(lvl);
    (i_gate == lvl) ##1 ((i_gate == lvl) && rd_st && $stable(sh_pol));
  endsequence
  // Confirmation lags the gate bit by one clock, data by one more
  sequence s_sw_on;
    sh_sw ##1 sh_sw ##1 (sh_sw && rd_st);
  endsequence
  sequence s_released;
    (!sh_sw && sh_pol == `GATE_OFF) ##1
      (!sh_sw && sh_pol == `GATE_OFF) ##1
      (!sh_sw && sh_pol == `GATE_OFF && rd_st);
  endsequence

  AST_PREADY: assert property (o_pready)
    else $error("pready low");
  AST_ERR_MAP: assert property (acc |-> o_pslverr == !mapped)
    else $error("pslverr wrong for address");
  AST_RD_IDLE: assert property (!(acc && !i_pwrite) |-> o_prdata == 32'h0)
    else $error("read data outside read access");
  AST_GATE_LVL: assert property (
    rd_st && $stable(i_gate) |-> o_prdata[`ST_GATE] == i_gate)
    else $error("gate level not shown");
  AST_POS_FREEZE: assert property (
    s_gate_held(1'b1) ##0 (sh_pol == `GATE_POS) |-> o_prdata[`ST_FROZEN])
    else $error("high gate did not freeze");
  AST_NEG_FREEZE: assert property (
    s_gate_held(1'b0) ##0 (sh_pol == `GATE_NEG) |-> o_prdata[`ST_FROZEN])
    else $error("low gate did not freeze");
  AST_SW_ACK: assert property (
    s_sw_on |-> o_prdata[`ST_SWOK] && o_prdata[`ST_FROZEN])
    else $error("software gate not confirmed");
  AST_RELEASE: assert property (
    s_released |-> !o_prdata[`ST_FROZEN] && !o_prdata[`ST_SWOK])
    else $error("counter still frozen");
  AST_PER_TMO: assert property (
    seen && idle > LIM && acc && !i_pwrite && i_paddr == `REG_PERIOD
    |-> o_prdata == `PER_MAX)
    else $error("period timeout value missing");
endmodule // egfp_monitor

bind egfp_top egfp_monitor #(.PER_TMO_TICKS(PER_TMO_TICKS)) i_egfp_monitor (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_enc_a(i_enc_a), .i_enc_b(i_enc_b),
  .i_enc_c(i_enc_c), .i_gate(i_gate), .i_ext_rst(i_ext_rst));

// >>> tb_egfp_top.sv
`timescale 1ns/1ps
`include "egfp_consts.vh"

module tb_egfp_top;
  reg         ref_clk = 1'b0;
  reg         rst_b   = 1'b0;
  reg         psel    = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite  = 1'b0;
  reg  [11:0] paddr   = 12'h000;
  reg  [31:0] pwdata  = 32'h00000000;
  reg         enc_b   = 1'b0;
  reg         enc_c   = 1'b0;
  reg         gate    = 1'b0;
  reg         ext_rst = 1'b0;
  reg         run     = 1'b0;
  reg  [15:0] half    = 16'h000A;
  reg  [31:0] rd;
  reg  [31:0] c0;
  reg         err;
  wire        pready;
  wire [31:0] prdata;
  wire        pslverr;
  wire        enc_a;
  integer     mismatches = 0;
  integer     compares   = 0;

  // 200 MHz reference clock
  always #2.5 ref_clk = !ref_clk;

  egfp_top #(.PER_TMO_TICKS(32'h000007D0)) i_egfp_top (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_enc_a(enc_a), .i_enc_b(enc_b),
    .i_enc_c(enc_c), .i_gate(gate), .i_ext_rst(ext_rst));

  egfp_enc_model i_egfp_enc_model (
    .i_ref_clk(ref_clk), .i_run(run), .i_half(half), .o_enc_a(enc_a));

  task test_done;
    begin
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge ref_clk);
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
        mismatches = mismatches + 1;
        test_done;
      end
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input [11:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h00000000);
      check(rd, exp);
    end
  endtask

  // Exactly n track-A periods, ending low
  task pulses(input integer n);
    begin
      run <= 1'b1;
      repeat (2 * n * half) @(posedge ref_clk);
      run <= 1'b0;
    end
  endtask

  // Frequency equals k*K/(10k+5) ticks for some whole period count k
  function f_ok(input [31:0] f, input [63:0] kk);
    integer k;
    begin
      f_ok = 1'b0;
      for (k = 1; k <= 20; k = k + 1)
        if (f === kk * k / (10 * k + 5))
          f_ok = 1'b1;
    end
  endfunction

  task t_regs;
    begin
      rdc(`REG_CTRL, 32'h00000000);
      rdc(`REG_FWIN, `RST_FWIN);
      rdc(`REG_FSCALE, `RST_FSCALE);
      rdc(`REG_FWAIT, `RST_FWAIT);
      rdc(`REG_PSCALE, `RST_PSCALE);
      wr(`REG_COUNT, 32'h00000055);
      rdc(`REG_COUNT, 32'h00000000);
      apb(1'b0, 12'h028, 32'h00000000);
      check({31'h0, err}, 32'h00000001);
    end
  endtask

  task t_gate;
    begin
      wr(`REG_CTRL, 32'h00000012);
      pulses(3);
      rdc(`REG_COUNT, 32'h00000003);
      gate <= 1'b1;
      rdc(`REG_LATCH2, 32'h00000003);
      rdc(`REG_STATUS, 32'h0000000D);
      pulses(2);
      rdc(`REG_COUNT, 32'h00000003);
      gate <= 1'b0;
      pulses(2);
      rdc(`REG_COUNT, 32'h00000005);
      wr(`REG_CTRL, 32'h00000020);
      rdc(`REG_STATUS, 32'h00000008);
      pulses(2);
      rdc(`REG_COUNT, 32'h00000005);
      gate <= 1'b1;
      pulses(2);
      rdc(`REG_COUNT, 32'h00000007);
      wr(`REG_CTRL, 32'h00000000);
      pulses(1);
      gate <= 1'b0;
      pulses(1);
      rdc(`REG_COUNT, 32'h00000009);
    end
  endtask

  task t_sw;
    begin
      wr(`REG_CTRL, 32'h00000001);
      rdc(`REG_STATUS, 32'h0000000A);
      pulses(2);
      rdc(`REG_COUNT, 32'h00000009);
      wr(`REG_CTRL, 32'h00000000);
      enc_b <= 1'b1;
      pulses(2);
      rdc(`REG_COUNT, 32'h00000007);
      rdc(`REG_STATUS, 32'h00000000);
      enc_b <= 1'b0;
    end
  endtask

  task t_freq;
    begin
      wr(`REG_FWIN, 32'h00000001); // window of ten A periods
      wr(`REG_CTRL, 32'h00000009);
      run     <= 1'b1;
      enc_c   <= 1'b1;
      ext_rst <= 1'b1;
      repeat (1000) @(posedge ref_clk);
      enc_c   <= 1'b0;
      ext_rst <= 1'b0;
      apb(1'b0, `REG_FREQ, 32'h00000000);
      check({31'h0, f_ok(rd, `FREQ_K_CENTI)}, 32'h1);
      wr(`REG_FSCALE, `FSCALE_HZ);
      repeat (1000) @(posedge ref_clk);
      apb(1'b0, `REG_FREQ, 32'h00000000);
      check({31'h0, f_ok(rd, `FREQ_K_HZ)}, 32'h1);
      run <= 1'b0;
      repeat (600) @(posedge ref_clk);
      apb(1'b0, `REG_FREQ, 32'h00000000);
      c0 = rd;
      repeat (600) @(posedge ref_clk);
      rdc(`REG_FREQ, c0);
      check({31'h0, f_ok(c0, `FREQ_K_HZ)}, 32'h1);
      wr(`REG_FWAIT, 32'h00000000);
      repeat (600) @(posedge ref_clk);
      rdc(`REG_FREQ, 32'h00000000);
      wr(`REG_CTRL, 32'h00000000);
    end
  endtask

  task t_period;
    integer i;
    reg [31:0] ps;
    begin
      half <= 16'h00FA;
      run  <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
        ps = (i == 0) ? 32'h0000000A : (i == 1) ? 32'h00000064 : 32'h000001F4;
        wr(`REG_PSCALE, ps);
        repeat (2000) @(posedge ref_clk);
        rdc(`REG_PERIOD, 32'h000009C4 / ps);
      end
      wr(`REG_PSCALE, `PSCALE_TB);
      half <= 16'h0064;
      repeat (2000) @(posedge ref_clk);
      rdc(`REG_PERIOD, 32'h00000064);
      run <= 1'b0;
      repeat (3000) @(posedge ref_clk);
      rdc(`REG_PERIOD, 32'h00000064);
      repeat (2000) @(posedge ref_clk);
      rdc(`REG_PERIOD, `PER_MAX);
    end
  endtask

  // Reset for four cycles, then the scenarios
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_gate;
    t_sw;
    t_freq;
    t_period;
    test_done;
  end
endmodule // tb_egfp_top
